// ### design/skx_core.sv
// Decode and execute of zero-test-skip and the two XOR instructions
//
// Function
// RULE1: Decode zero-test opcode; flags stay unchanged.
// RULE2: Zero register discards next word, two cycles.
// RULE3: Skipped two-word instruction costs three cycles.
// RULE4: Access bit 0 access bank, 1 bank select.
// RULE5: Decode XOR-literal opcode with 8-bit literal.
// RULE6: XOR literal into working register, one cycle.
// RULE7: Decode XOR-file opcode with destination, access bits.
// RULE8: Destination 0 working register, 1 file register.
// RULE9: Read Q2, process Q3, write Q4.
// RULE10: Negative from bit 7, zero on zero result.
`timescale 1ns/100ps
`default_nettype none
module skx_core (
  input  wire logic                                core_clk_in,
  input  wire logic                                reset_n_in,
  // Fetch side
  input  wire logic                                instr_valid_in,
  input  wire logic [skx_pkg::WORD_W-1:0]          instr_word_in,
  input  wire logic                                next_two_word_in,
  output var  logic                                instr_ready_out,
  output var  logic                                discard_out,
  output var  logic                                done_out,
  // Data register file side
  output var  logic [skx_pkg::ADDR_W-1:0]          file_addr_out,
  output var  logic                                file_rd_out,
  input  wire logic [skx_pkg::DATA_W-1:0]          file_rdata_in,
  output var  logic                                file_wr_out,
  output var  logic [skx_pkg::DATA_W-1:0]          file_wdata_out,
  // Register port
  input  wire logic [skx_pkg::REG_ADDR_W-1:0]      reg_addr_in,
  input  wire logic [skx_pkg::DATA_W-1:0]          reg_wdata_in,
  input  wire logic                                reg_wr_in,
  input  wire logic                                reg_rd_in,
  output var  logic [skx_pkg::DATA_W-1:0]          reg_rdata_out
);

  logic [3:0]                       phase;
  logic                             q1;
  logic                             q2;
  logic                             q3;
  logic                             q4;
  skx_pkg::skx_state_t              state;
  skx_pkg::skx_state_t              next_state;
  skx_pkg::skx_op_t                 op;
  skx_pkg::skx_op_t                 next_op;
  logic [skx_pkg::WORD_W-1:0]       ir;
  logic [skx_pkg::WORD_W-1:0]       next_ir;
  logic [skx_pkg::DATA_W-1:0]       opnd;
  logic [skx_pkg::DATA_W-1:0]       next_opnd;
  logic [skx_pkg::DATA_W-1:0]       result;
  logic [skx_pkg::DATA_W-1:0]       next_result;
  logic [skx_pkg::DATA_W-1:0]       working_register;
  logic [skx_pkg::DATA_W-1:0]       next_working_register;
  logic [skx_pkg::BANK_W-1:0]       bank_select_register;
  logic [skx_pkg::BANK_W-1:0]       next_bank_select_register;
  logic                             flag_n;
  logic                             next_flag_n;
  logic                             flag_z;
  logic                             next_flag_z;
  logic [skx_pkg::ADDR_W-1:0]       next_file_addr;
  logic [skx_pkg::CYC_W-1:0]        cyc;
  logic [skx_pkg::CYC_W-1:0]        next_cyc;
  logic [skx_pkg::CYC_W-1:0]        last_cycles;
  logic [skx_pkg::CYC_W-1:0]        next_last_cycles;
  logic [skx_pkg::DATA_W-1:0]       next_rdata;
  logic                             finish;
  logic [skx_pkg::CYC_W-1:0]        cyc_now;

  skx_quarter_gen u_quarter (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .phase_out   (phase)
  );

  assign q1 = phase[0];
  assign q2 = phase[1];
  assign q3 = phase[2];
  assign q4 = phase[3];

  // Maps an 8-bit operand address to the 12-bit data space
  function automatic logic [skx_pkg::ADDR_W-1:0] map_addr(
    input logic [skx_pkg::WORD_W-1:0] word,
    input logic [skx_pkg::BANK_W-1:0] bank);
    logic [skx_pkg::BANK_W-1:0] sel;
    sel = bank;
    if (!word[skx_pkg::FLD_ACCESS])
      sel = (word[7:0] < skx_pkg::ACCESS_SPLIT) ? skx_pkg::ACCESS_LO_BANK
                                                : skx_pkg::ACCESS_HI_BANK;
    return {sel, word[7:0]};
  endfunction

  // A word is taken every Q1; in skip states it is the discarded one
  assign instr_ready_out = q1;
  assign discard_out     = q1 && instr_valid_in && (state != skx_pkg::ST_RUN);        // see RULE2
  assign file_rd_out     = q2 && (state == skx_pkg::ST_RUN)
                           && ((op == skx_pkg::OP_TST) || (op == skx_pkg::OP_XWF));   // see RULE9
  assign file_wr_out     = q4 && (state == skx_pkg::ST_RUN)
                           && (op == skx_pkg::OP_XWF) && ir[skx_pkg::FLD_DEST];     // see RULE8
  assign cyc_now         = cyc + skx_pkg::CYC_PLAIN;
  assign done_out        = q4 && finish;

  always_comb
  begin
    next_state                = state;
    next_op                   = op;
    next_ir                   = ir;
    next_opnd                 = opnd;
    next_result               = result;
    next_working_register     = working_register;
    next_bank_select_register = bank_select_register;
    next_flag_n               = flag_n;
    next_flag_z               = flag_z;
    next_file_addr            = file_addr_out;
    next_cyc                  = cyc;
    next_last_cycles          = last_cycles;
    next_rdata                = 8'h00;
    finish                    = 1'b0;

    if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        skx_pkg::REG_ACCUM:  next_rdata = working_register;
        skx_pkg::REG_BANK:   next_rdata = {4'h0, bank_select_register};
        skx_pkg::REG_STATUS: next_rdata = {6'h00, flag_n, flag_z};
        skx_pkg::REG_CYCLES: next_rdata = {6'h00, last_cycles};
        default:             next_rdata = 8'h00;
      endcase
    end

    // Software writes first so an instruction result in the same cycle wins
    if (reg_wr_in)
    begin
      if (reg_addr_in == skx_pkg::REG_ACCUM)
        next_working_register = reg_wdata_in;
      if (reg_addr_in == skx_pkg::REG_BANK)
        next_bank_select_register = reg_wdata_in[skx_pkg::BANK_W-1:0];
      if (reg_addr_in == skx_pkg::REG_STATUS)
      begin
        next_flag_z = reg_wdata_in[skx_pkg::STAT_Z_BIT];
        next_flag_n = reg_wdata_in[skx_pkg::STAT_N_BIT];
      end
    end

    if (q1)
    begin
      next_op = skx_pkg::OP_NONE;
      if ((state == skx_pkg::ST_RUN) && instr_valid_in)
      begin
        next_op        = skx_pkg::skx_decode(instr_word_in);              // see RULE1 RULE5 RULE7
        next_ir        = instr_word_in;
        next_file_addr = map_addr(instr_word_in, bank_select_register);   // see RULE4
      end
    end

    if (q2)
      next_opnd = (op == skx_pkg::OP_XLW) ? ir[7:0] : file_rdata_in;       // see RULE9

    if (q3)
      next_result = working_register ^ opnd;                               // see RULE6

    if (q4)
    begin
      unique case (state)
        skx_pkg::ST_RUN:
        begin
          if (op == skx_pkg::OP_TST)
          begin
            // Flags are deliberately left alone here
            if (opnd == 8'h00)
              next_state = next_two_word_in ? skx_pkg::ST_SKIP2
                                            : skx_pkg::ST_SKIP;           // see RULE2 RULE3
            else
              finish = 1'b1;
          end
          else if (op != skx_pkg::OP_NONE)
          begin
            finish      = 1'b1;
            next_flag_n = result[7];                                       // see RULE10
            next_flag_z = (result == 8'h00);                               // see RULE10
            if ((op == skx_pkg::OP_XLW) || !ir[skx_pkg::FLD_DEST])
              next_working_register = result;                              // see RULE6 RULE8
          end
        end
        skx_pkg::ST_SKIP:
        begin
          next_state = skx_pkg::ST_RUN;
          finish     = 1'b1;
        end
        skx_pkg::ST_SKIP2:
          next_state = skx_pkg::ST_SKIP;                                   // see RULE3
      endcase
      if (finish)
      begin
        next_last_cycles = cyc_now;
        next_cyc         = 2'h0;
      end
      else if ((state != skx_pkg::ST_RUN) || (op == skx_pkg::OP_TST))
        next_cyc = cyc_now;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state                <= skx_pkg::ST_RUN;
      op                   <= skx_pkg::OP_NONE;
      ir                   <= 16'h0000;
      opnd                 <= 8'h00;
      result               <= 8'h00;
      working_register     <= skx_pkg::ACCUM_RST;
      bank_select_register <= skx_pkg::BANK_RST;
      flag_n               <= 1'b0;
      flag_z               <= 1'b0;
      file_addr_out        <= 12'h000;
      cyc                  <= 2'h0;
      last_cycles          <= 2'h0;
      reg_rdata_out        <= 8'h00;
    end
    else
    begin
      state                <= next_state;
      op                   <= next_op;
      ir                   <= next_ir;
      opnd                 <= next_opnd;
      result               <= next_result;
      working_register     <= next_working_register;
      bank_select_register <= next_bank_select_register;
      flag_n               <= next_flag_n;
      flag_z               <= next_flag_z;
      file_addr_out        <= next_file_addr;
      cyc                  <= next_cyc;
      last_cycles          <= next_last_cycles;
      reg_rdata_out        <= next_rdata;
    end
  end

  // The write data is the processed result, stable through Q4
  assign file_wdata_out = result;                                          // see RULE8

  // Checks
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence s_nop_cycle;
    (state == skx_pkg::ST_SKIP) [*4];
  endsequence

  sequence s_nop_cycle2;
    (state == skx_pkg::ST_SKIP2) [*4];
  endsequence

  sequence s_tst_q4;
    q4 && (state == skx_pkg::ST_RUN) && (op == skx_pkg::OP_TST);
  endsequence

  property p_decode_tst;
    (q1 && (state == skx_pkg::ST_RUN) && instr_valid_in
      && (instr_word_in[15:9] == skx_pkg::OPC_TST)) |=> (op == skx_pkg::OP_TST);
  endproperty
  a_decode_tst: assert property (p_decode_tst) // see RULE1
    else $error("zero-test word not decoded");

  property p_tst_flags;
    (s_tst_q4 ##0 !reg_wr_in) |=> (flag_n == $past(flag_n)) && (flag_z == $past(flag_z));
  endproperty
  a_tst_flags: assert property (p_tst_flags) // see RULE1
    else $error("zero-test changed a flag");

  property p_skip_one;
    (s_tst_q4 ##0 ((opnd == 8'h00) && !next_two_word_in))
      |=> s_nop_cycle ##1 ((state == skx_pkg::ST_RUN) && (last_cycles == skx_pkg::CYC_SKIP));
  endproperty
  a_skip_one: assert property (p_skip_one) // see RULE2
    else $error("single skip not two cycles");

  property p_no_skip;
    (s_tst_q4 ##0 (opnd != 8'h00))
      |-> done_out ##1 ((state == skx_pkg::ST_RUN) && (last_cycles == skx_pkg::CYC_PLAIN));
  endproperty
  a_no_skip: assert property (p_no_skip) // see RULE2
    else $error("nonzero test did not complete in one cycle");

  property p_skip_two;
    (s_tst_q4 ##0 ((opnd == 8'h00) && next_two_word_in))
      |=> s_nop_cycle2 ##1 s_nop_cycle ##1 (last_cycles == skx_pkg::CYC_SKIP2);
  endproperty
  a_skip_two: assert property (p_skip_two) // see RULE3
    else $error("two-word skip not three cycles");

  property p_access_bank;
    (q1 && (state == skx_pkg::ST_RUN) && instr_valid_in && !instr_word_in[skx_pkg::FLD_ACCESS])
      |=> (file_addr_out[11:8] == (($past(instr_word_in[7:0]) < skx_pkg::ACCESS_SPLIT)
                                   ? skx_pkg::ACCESS_LO_BANK : skx_pkg::ACCESS_HI_BANK))
          && (file_addr_out[7:0] == $past(instr_word_in[7:0]));
  endproperty
  a_access_bank: assert property (p_access_bank) // see RULE4
    else $error("access bank address wrong");

  property p_banked_addr;
    (q1 && (state == skx_pkg::ST_RUN) && instr_valid_in && instr_word_in[skx_pkg::FLD_ACCESS])
      |=> (file_addr_out == {$past(bank_select_register), $past(instr_word_in[7:0])});
  endproperty
  a_banked_addr: assert property (p_banked_addr) // see RULE4
    else $error("banked address wrong");

  property p_decode_xlw;
    (q1 && (state == skx_pkg::ST_RUN) && instr_valid_in
      && (instr_word_in[15:8] == skx_pkg::OPC_XLW)) |=> (op == skx_pkg::OP_XLW);
  endproperty
  a_decode_xlw: assert property (p_decode_xlw) // see RULE5
    else $error("literal XOR not decoded");

  property p_xlw;
    (q4 && (state == skx_pkg::ST_RUN) && (op == skx_pkg::OP_XLW))
      |-> done_out ##1 (working_register == ($past(working_register) ^ $past(ir[7:0])));
  endproperty
  a_xlw: assert property (p_xlw) // see RULE6
    else $error("literal XOR result wrong");

  property p_decode_xwf;
    (q1 && (state == skx_pkg::ST_RUN) && instr_valid_in
      && (instr_word_in[15:10] == skx_pkg::OPC_XWF)) |=> (op == skx_pkg::OP_XWF);
  endproperty
  a_decode_xwf: assert property (p_decode_xwf) // see RULE7
    else $error("file XOR not decoded");

  property p_xwf_file;
    (q4 && (state == skx_pkg::ST_RUN) && (op == skx_pkg::OP_XWF) && ir[skx_pkg::FLD_DEST])
      |-> file_wr_out && (file_wdata_out == (working_register ^ opnd));
  endproperty
  a_xwf_file: assert property (p_xwf_file) // see RULE8
    else $error("file XOR not written to file");

  property p_xwf_working_register;
    (q4 && (state == skx_pkg::ST_RUN) && (op == skx_pkg::OP_XWF) && !ir[skx_pkg::FLD_DEST])
      |-> !file_wr_out ##1 (working_register == $past(working_register ^ opnd));
  endproperty
  a_xwf_working_register: assert property (p_xwf_working_register) // see RULE8
    else $error("file XOR not written to working register");

  property p_phases;
    (q2 && (state == skx_pkg::ST_RUN) && (op == skx_pkg::OP_XWF))
      |-> file_rd_out ##1 (q3 && !file_wr_out) ##1 q4;
  endproperty
  a_phases: assert property (p_phases) // see RULE9
    else $error("file XOR phase order wrong");

  property p_flags;
    (q4 && (state == skx_pkg::ST_RUN)
      && ((op == skx_pkg::OP_XLW) || (op == skx_pkg::OP_XWF)))
      |=> (flag_n == $past(result[7])) && (flag_z == ($past(result) == 8'h00));
  endproperty
  a_flags: assert property (p_flags) // see RULE10
    else $error("XOR flags wrong");

endmodule
`default_nettype wire

// ### pkg/skx_pkg.sv
// Constants, types and helpers shared by the skip-test and XOR execute block
`default_nettype none
package skx_pkg;

  localparam int WORD_W = 16;
  localparam int DATA_W = 8;
  localparam int BANK_W = 4;
  localparam int ADDR_W = 12;
  localparam int CYC_W  = 2;

  // Opcode patterns, compared against the top bits of the word
  localparam logic [6:0] OPC_TST     = 7'h33;
  localparam logic [7:0] OPC_XLW     = 8'h0A;
  localparam logic [5:0] OPC_XWF     = 6'h06;
  localparam int         FLD_ACCESS  = 8;
  localparam int         FLD_DEST    = 9;

  // Access bank: low half of bank 0 and high half of the top bank
  localparam logic [7:0]        ACCESS_SPLIT   = 8'h80;
  localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hF;

  // Register port map
  localparam int               REG_ADDR_W = 4;
  localparam logic [3:0]       REG_ACCUM  = 4'h0;
  localparam logic [3:0]       REG_BANK   = 4'h1;
  localparam logic [3:0]       REG_STATUS = 4'h2;
  localparam logic [3:0]       REG_CYCLES = 4'h3;
  localparam int               STAT_Z_BIT = 0;
  localparam int               STAT_N_BIT = 1;

  // Reset values
  localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
  localparam logic [BANK_W-1:0] BANK_RST  = 4'h0;

  // Timing: one instruction cycle is four core clocks, one per quarter
  localparam int             CORE_PERIOD_NS = 10;
  localparam int             QUARTERS       = 4;
  localparam logic [CYC_W-1:0] CYC_PLAIN    = 2'h1;
  localparam logic [CYC_W-1:0] CYC_SKIP     = 2'h2;
  localparam logic [CYC_W-1:0] CYC_SKIP2    = 2'h3;

  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } skx_phase_t;

  typedef enum logic [2:0] {
    ST_RUN   = 3'h1,
    ST_SKIP  = 3'h2,
    ST_SKIP2 = 3'h4
  } skx_state_t;

  typedef enum logic [3:0] {
    OP_NONE = 4'h1,
    OP_TST  = 4'h2,
    OP_XLW  = 4'h4,
    OP_XWF  = 4'h8
  } skx_op_t;

  function automatic skx_op_t skx_decode(input logic [WORD_W-1:0] word);
    skx_op_t op;
    op = OP_NONE;
    if (word[15:9] == OPC_TST)
      op = OP_TST;
    else if (word[15:8] == OPC_XLW)
      op = OP_XLW;
    else if (word[15:10] == OPC_XWF)
      op = OP_XWF;
    return op;
  endfunction

endpackage
`default_nettype wire

// ### design/skx_quarter_gen.sv
// Quarter-phase divider: one-hot enable per core clock, Q1 to Q4
`timescale 1ns/100ps
`default_nettype none
module skx_quarter_gen (
  input  wire logic       core_clk_in,
  input  wire logic       reset_n_in,
  output var  logic [3:0] phase_out
);

  logic [3:0] next_phase;

  always_comb
  begin
    next_phase = {phase_out[2:0], phase_out[3]};
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      phase_out <= skx_pkg::PH_Q1;
    else
      phase_out <= next_phase;
  end

endmodule
`default_nettype wire

// ### verification/skx_file_model.sv
// Behavioural data register file that sits on the far side of the core
`timescale 1ns/100ps
`default_nettype none
module skx_file_model (
  input  wire logic                       core_clk_in,
  input  wire logic [skx_pkg::ADDR_W-1:0] file_addr_in,
  input  wire logic                       file_rd_in,
  input  wire logic                       file_wr_in,
  input  wire logic [skx_pkg::DATA_W-1:0] file_wdata_in,
  output var  logic [skx_pkg::DATA_W-1:0] file_rdata_out
);
  logic [skx_pkg::DATA_W-1:0] mem [0:4095];
  logic [skx_pkg::DATA_W-1:0] last_rd;

  initial
  begin
    foreach (mem[i]) mem[i] = 8'h00;
    last_rd = 8'h00;
  end

  // Outside the read quarter the bus shows junk, never the last value
  assign file_rdata_out = file_rd_in ? mem[file_addr_in] : ~last_rd;

  always @(posedge core_clk_in)
  begin
    if (file_rd_in)
      last_rd <= mem[file_addr_in];
    if (file_wr_in)
      mem[file_addr_in] <= file_wdata_in;
  end
endmodule
`default_nettype wire

// ### verification/skx_core_tb_top.sv
// Self-checking testbench for the skip-test and XOR execute core
`timescale 1ns/100ps
`default_nettype none
module skx_core_tb_top;
  localparam logic [15:0] NOP_WORD = 16'hFFFF;
  logic        core_clk, reset_n, instr_valid, next_two_word, instr_ready, discard, done;
  logic [15:0] instr_word;
  logic [11:0] file_addr;
  logic        file_rd, file_wr, reg_wr, reg_rd;
  logic [7:0]  file_rdata, file_wdata, reg_wdata, reg_rdata, v, w, r, st0;
  logic [3:0]  reg_addr;
  int          err_count, samples_checked, done_cnt, discard_cnt, dis0, done0;
  logic [7:0]  lit [3] = '{8'hAF, 8'h1A, 8'h80};
  logic [15:0] xw [4] = '{16'h1A10, 16'h1B20, 16'h1890, 16'h1930};
  logic [11:0] xa [4] = '{12'h010, 12'h520, 12'hF90, 12'h530};
  logic [7:0]  xm [4] = '{8'hAF, 8'h55, 8'hC3, 8'h5A};
  logic [15:0] tword [3] = '{16'h6640, 16'h6740, 16'h6640};
  logic [11:0] taddr [3] = '{12'h040, 12'h540, 12'h040};
  logic [7:0]  tm [3] = '{8'h01, 8'h00, 8'h00};
  int          tcyc [3] = '{1, 2, 3};

  skx_core dut_u (
    .core_clk_in(core_clk), .reset_n_in(reset_n), .instr_valid_in(instr_valid),
    .instr_word_in(instr_word), .next_two_word_in(next_two_word),
    .instr_ready_out(instr_ready), .discard_out(discard), .done_out(done),
    .file_addr_out(file_addr), .file_rd_out(file_rd), .file_rdata_in(file_rdata),
    .file_wr_out(file_wr), .file_wdata_out(file_wdata), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata)
  );

  skx_file_model model_u (
    .core_clk_in(core_clk), .file_addr_in(file_addr), .file_rd_in(file_rd),
    .file_wr_in(file_wr), .file_wdata_in(file_wdata), .file_rdata_out(file_rdata)
  );

  always #5 core_clk = ~core_clk;

  always @(negedge core_clk)
  begin
    if (done === 1'b1) done_cnt++;
    if (discard === 1'b1) discard_cnt++;
  end

  task automatic give_verdict();
    $display("Mismatches %0d, comparisons %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_cnt(input string name, input int exp, input int got);
    samples_checked++;
    if (got != exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask

  function automatic logic [7:0] exp_status(input logic [7:0] res);
    logic [7:0] s;
    s = 8'h00;
    s[skx_pkg::STAT_N_BIT] = res[7];
    s[skx_pkg::STAT_Z_BIT] = (res == 8'h00);
    return s;
  endfunction

  // Leaves the bench just past the edge that closes a Q1
  task automatic exec(input logic [15:0] wd, input logic tw, input logic do_sync);
    int i;
    if (do_sync)
    begin
      @(negedge core_clk);
      for (i = 0; i < 8 && instr_ready !== 1'b1; i++) @(negedge core_clk);
      @(posedge core_clk);
    end
    repeat (3) @(posedge core_clk);
    instr_word    <= wd;
    next_two_word <= tw;
    @(posedge core_clk);
    instr_word    <= NOP_WORD;
  endtask

  task automatic wait_done(input int n);
    int i;
    for (i = 0; i < 40 && done_cnt < n; i++) @(negedge core_clk);
    chk_cnt("done count", n, done_cnt);
  endtask

  task automatic chk_regs(input logic [7:0] ew, input logic [7:0] es, input logic [7:0] ec);
    reg_read(skx_pkg::REG_ACCUM, v);
    chk("working register", ew, v);
    reg_read(skx_pkg::REG_STATUS, v);
    chk("status", es, v);
    reg_read(skx_pkg::REG_CYCLES, v);
    chk("cycles", ec, v);
  endtask

  initial
  begin
    #50000;
    err_count++;
    $display("Watchdog expired");
    give_verdict();
  end

  initial
  begin
    core_clk = 1'b0;
    reset_n = 1'b0;
    instr_valid = 1'b1;
    instr_word = NOP_WORD;
    next_two_word = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    err_count = 0;
    samples_checked = 0;
    done_cnt = 0;
    discard_cnt = 0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    foreach (xa[i])
    begin
      reg_read(4'(i), v);
      chk("reset value", 8'h00, v);
    end
    reg_write(4'h5, 8'h3C);
    reg_read(4'h5, v);
    chk("unmapped", 8'h00, v);
    // Literal XOR: plain, zero and negative results
    w = 8'hB5;
    reg_write(skx_pkg::REG_ACCUM, w);
    foreach (lit[i])
    begin
      exec({skx_pkg::OPC_XLW, lit[i]}, 1'b0, 1'b1);
      wait_done(done_cnt + 1);
      w = w ^ lit[i];
      chk_regs(w, exp_status(w), 8'h01);
    end
    // File XOR: both destinations, access bank low and high, bank select
    reg_write(skx_pkg::REG_BANK, 8'h05);
    foreach (xw[i])
    begin
      model_u.mem[xa[i]] = xm[i];
      exec(xw[i], 1'b0, 1'b1);
      wait_done(done_cnt + 1);
      r = w ^ xm[i];
      if (xw[i][skx_pkg::FLD_DEST] == 1'b0) w = r;
      chk_regs(w, exp_status(r), 8'h01);
      chk("file value", xw[i][skx_pkg::FLD_DEST] ? r : xm[i], model_u.mem[xa[i]]);
    end
    // Zero test followed at once by a literal XOR that a skip must discard
    foreach (tword[i])
    begin
      model_u.mem[taddr[i]] = tm[i];
      reg_read(skx_pkg::REG_STATUS, st0);
      dis0 = discard_cnt;
      // A plain test ends in its Q4, before the next word is offered, so done0 is taken first
      done0 = done_cnt;
      exec(tword[i], tcyc[i] == 3, 1'b1);
      exec({skx_pkg::OPC_XLW, 8'hFF}, 1'b0, 1'b0);
      wait_done(done0 + (tcyc[i] > 1 ? 1 : 2));
      chk_cnt("discards", tcyc[i] - 1, discard_cnt - dis0);
      if (tcyc[i] == 1) w = w ^ 8'hFF;
      chk_regs(w, tcyc[i] > 1 ? st0 : exp_status(w), 8'(tcyc[i]));
    end
    give_verdict();
  end
endmodule
`default_nettype wire
